// ==== verilog/aicp_map.svh ====
// Purpose: Constants for the ADC two-wire command port
// Assumes: Included by the package and the port module
// Notes: Times in ns, counts derived for a 40 ns system clock
`ifndef AICP_MAP_SVH
`define AICP_MAP_SVH
`define AICP_CLK_NS 40
`define AICP_RELEASE_WIDTH_NS 1000
`define AICP_RELEASE_CYCLES ((`AICP_RELEASE_WIDTH_NS + `AICP_CLK_NS - 1) / `AICP_CLK_NS)
`define AICP_TIMEOUT_NORMAL 14000
`define AICP_TIMEOUT_TURBO 28000
`define AICP_GC_ADDR 7'h00
`define AICP_GC_RESET 8'h06
`define AICP_POS_FULL 24'h7fffff
`define AICP_NEG_FULL 24'h800000
`define AICP_OP_RESET 7'h03
`define AICP_OP_START 7'h04
`define AICP_OP_SLEEP 7'h01
`define AICP_OP_FETCH 4'h1
`define AICP_OP_REG_RD 4'h2
`define AICP_OP_REG_WR 4'h4
`endif

// ==== verilog/aicp_pkg.sv ====
// Purpose: Types for the ADC two-wire command port
// Assumes: aicp_map.svh holds the numbers
// Notes: Decode function used by the system clock domain only
`include "aicp_map.svh"
package aicp_pkg;
  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_AACK, L_RX, L_RACK, L_TX, L_TACK, L_SKIP
  } aicp_link_st_t;

  typedef enum logic [2:0] {
    C_NONE, C_RESET, C_START, C_SLEEP, C_FETCH, C_REG_RD, C_REG_WR
  } aicp_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic is_data;
    logic gen_call;
  } aicp_byte_evt_t;

  function automatic aicp_cmd_t aicp_decode(input logic [7:0] b);
    aicp_cmd_t c;
    c = C_NONE;
    if (b[7:1] == `AICP_OP_RESET) c = C_RESET;
    else if (b[7:1] == `AICP_OP_START) c = C_START;
    else if (b[7:1] == `AICP_OP_SLEEP) c = C_SLEEP;
    else if (b[7:4] == `AICP_OP_FETCH) c = C_FETCH;
    else if (b[7:4] == `AICP_OP_REG_RD) c = C_REG_RD;
    else if (b[7:4] == `AICP_OP_REG_WR) c = C_REG_WR;
    return c;
  endfunction
endpackage

// ==== verilog/aicp_port.sv ====
// Purpose: Two-wire target port, command decoder and ready pin of the ADC
// Assumes: scl/sda oversampled on link_clk; core supplies results and mod_tick
// Notes: Bytes cross to clk by toggle; the result word is static while read
`timescale 1ns/1ps
`include "aicp_map.svh"
module aicp_port #(
  parameter int TIMEOUT_NORMAL = `AICP_TIMEOUT_NORMAL,
  parameter int TIMEOUT_TURBO = `AICP_TIMEOUT_TURBO
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic result_ready_n_o,
  output logic result_ready_n_oe,
  input wire logic [6:0] dev_addr,
  input wire logic conversion_mode_select,
  input wire logic turbo_mode,
  input wire logic mod_tick,
  input wire logic conv_done,
  input wire logic [23:0] conv_result,
  input wire logic conv_pos_ovr,
  input wire logic conv_neg_ovr,
  input wire logic conv_busy,
  input wire logic [31:0] reg_file,
  output logic conv_start,
  output logic conv_restart,
  output logic sleep_command,
  output logic device_reset,
  output logic cont_mode,
  output logic reg_wr_en,
  output logic [1:0] reg_wr_addr,
  output logic [7:0] reg_wr_data
);
  // ---------------- Link domain ----------------
  logic [2:0] scl_sy_ff;
  logic [2:0] sda_sy_ff;
  logic scl_f_ff, sda_f_ff, nxt_scl_f, nxt_sda_f;
  aicp_pkg::aicp_link_st_t st_ff, nxt_st;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] shift_ff, nxt_shift;
  logic rw_ff, nxt_rw, gc_ff, nxt_gc, wr_pend_ff, nxt_wr_pend;
  logic [1:0] idx_ff, nxt_idx;
  logic oe_ff, nxt_oe, busy_ff, nxt_busy;
  logic evt_tgl_ff, nxt_evt_tgl, act_tgl_ff, nxt_act_tgl;
  aicp_pkg::aicp_byte_evt_t evt_ff, nxt_evt;
  logic [2:0] to_sy_ff;
  logic to_tgl_ff, nxt_to_tgl;
  logic scl_rise, scl_fall, start_c, stop_c, to_hit;
  logic [23:0] out_word_ff;

  function automatic logic [7:0] pick_byte(input logic [23:0] w, input logic [1:0] i);
    logic [7:0] b;
    b = 8'h00;
    if (i == 2'h0) b = w[23:16];
    else if (i == 2'h1) b = w[15:8];
    else if (i == 2'h2) b = w[7:0];
    return b;
  endfunction

  always_comb begin
    nxt_scl_f = (scl_sy_ff[1] == scl_sy_ff[2]) ? scl_sy_ff[1] : scl_f_ff;
    nxt_sda_f = (sda_sy_ff[1] == sda_sy_ff[2]) ? sda_sy_ff[1] : sda_f_ff;
    scl_rise = ~scl_f_ff & nxt_scl_f;
    scl_fall = scl_f_ff & ~nxt_scl_f;
    start_c = scl_f_ff & nxt_scl_f & sda_f_ff & ~nxt_sda_f;
    stop_c = scl_f_ff & nxt_scl_f & ~sda_f_ff & nxt_sda_f;
    to_hit = to_sy_ff[1] ^ to_sy_ff[2];
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_rw = rw_ff;
    nxt_gc = gc_ff;
    nxt_wr_pend = wr_pend_ff;
    nxt_idx = idx_ff;
    nxt_oe = oe_ff;
    nxt_busy = busy_ff;
    nxt_evt_tgl = evt_tgl_ff;
    nxt_evt = evt_ff;
    nxt_act_tgl = act_tgl_ff;
    if (busy_ff && (scl_rise || scl_fall || stop_c)) begin
      nxt_act_tgl = ~act_tgl_ff;
    end
    if (start_c) begin
      nxt_st = aicp_pkg::L_ADDR;
      nxt_busy = 1'b1;
      nxt_bit = 4'h0;
      nxt_oe = 1'b0;
      nxt_wr_pend = 1'b0;
    end else if (stop_c || to_hit) begin
      nxt_st = aicp_pkg::L_IDLE;
      nxt_busy = 1'b0;
      nxt_oe = 1'b0;
    end else begin
      unique case (st_ff)
        aicp_pkg::L_IDLE, aicp_pkg::L_SKIP: begin
        end
        aicp_pkg::L_ADDR, aicp_pkg::L_RX: begin
          if (scl_rise && bit_ff != 4'h8) begin
            nxt_shift = {shift_ff[6:0], sda_f_ff};
            nxt_bit = bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            if (st_ff == aicp_pkg::L_ADDR) begin
              if (shift_ff[7:1] == dev_addr ||
                  (shift_ff[7:1] == `AICP_GC_ADDR && !shift_ff[0])) begin
                nxt_oe = 1'b1;
                nxt_st = aicp_pkg::L_AACK;
                nxt_rw = shift_ff[0];
                nxt_gc = (shift_ff[7:1] == `AICP_GC_ADDR);
              end else begin
                nxt_st = aicp_pkg::L_SKIP;
              end
            end else begin
              nxt_oe = 1'b1;
              nxt_st = aicp_pkg::L_RACK;
              nxt_evt.data = shift_ff;
              nxt_evt.is_data = wr_pend_ff;
              nxt_evt.gen_call = gc_ff;
              nxt_evt_tgl = ~evt_tgl_ff;
              nxt_wr_pend = !gc_ff && !wr_pend_ff && shift_ff[7:4] == `AICP_OP_REG_WR;
            end
          end
        end
        aicp_pkg::L_AACK: begin
          if (scl_fall) begin
            if (rw_ff) begin
              nxt_shift = pick_byte(out_word_ff, 2'h0);
              nxt_oe = ~nxt_shift[7];
              nxt_idx = 2'h1;
              nxt_bit = 4'h1;
              nxt_st = aicp_pkg::L_TX;
            end else begin
              nxt_oe = 1'b0;
              nxt_bit = 4'h0;
              nxt_st = aicp_pkg::L_RX;
            end
          end
        end
        aicp_pkg::L_RACK: begin
          if (scl_fall) begin
            nxt_oe = 1'b0;
            nxt_bit = 4'h0;
            nxt_st = aicp_pkg::L_RX;
          end
        end
        aicp_pkg::L_TX: begin
          if (scl_fall) begin
            if (bit_ff == 4'h8) begin
              nxt_oe = 1'b0;
              nxt_st = aicp_pkg::L_TACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_oe = ~nxt_shift[7];
              nxt_bit = bit_ff + 4'h1;
            end
          end
        end
        aicp_pkg::L_TACK: begin
          if (scl_rise && sda_f_ff) begin
            nxt_st = aicp_pkg::L_SKIP;
          end else if (scl_fall) begin
            nxt_shift = pick_byte(out_word_ff, idx_ff);
            nxt_oe = ~nxt_shift[7];
            nxt_idx = (idx_ff == 2'h3) ? idx_ff : idx_ff + 2'h1;
            nxt_bit = 4'h1;
            nxt_st = aicp_pkg::L_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
      scl_f_ff <= 1'b1;
      sda_f_ff <= 1'b1;
      st_ff <= aicp_pkg::L_IDLE;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      gc_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      idx_ff <= 2'h0;
      oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      evt_tgl_ff <= 1'b0;
      evt_ff <= '0;
      act_tgl_ff <= 1'b0;
      to_sy_ff <= 3'h0;
    end else begin
      scl_sy_ff <= {scl_sy_ff[1:0], scl_i};
      sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
      scl_f_ff <= nxt_scl_f;
      sda_f_ff <= nxt_sda_f;
      st_ff <= nxt_st;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      rw_ff <= nxt_rw;
      gc_ff <= nxt_gc;
      wr_pend_ff <= nxt_wr_pend;
      idx_ff <= nxt_idx;
      oe_ff <= nxt_oe;
      busy_ff <= nxt_busy;
      evt_tgl_ff <= nxt_evt_tgl;
      evt_ff <= nxt_evt;
      act_tgl_ff <= nxt_act_tgl;
      to_sy_ff <= {to_sy_ff[1:0], to_tgl_ff};
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_ff;

  // ---------------- System clock domain ----------------
  logic [2:0] ev_sy_ff, act_sy_ff;
  logic [2:0] busy_sy_ff;
  logic [14:0] to_cnt_ff, nxt_to_cnt;
  logic [23:0] nxt_out_word, result_ff, nxt_result;
  logic rdy_n_ff, nxt_rdy_n;
  logic [5:0] rel_cnt_ff, nxt_rel_cnt;
  logic mode_ff, nxt_mode;
  logic [1:0] wa_ff, nxt_wa;
  logic start_ff, nxt_start, restart_ff, nxt_restart, sleep_ff, nxt_sleep;
  logic rst_ff, nxt_rst, wr_ff, nxt_wr;
  logic [7:0] wd_ff, nxt_wd;
  logic ev_hit, act_hit;
  logic [14:0] to_limit;
  aicp_pkg::aicp_cmd_t cmd;

  always_comb begin
    ev_hit = ev_sy_ff[1] ^ ev_sy_ff[2];
    act_hit = act_sy_ff[1] ^ act_sy_ff[2];
    to_limit = turbo_mode ? TIMEOUT_TURBO[14:0] : TIMEOUT_NORMAL[14:0];
    cmd = aicp_pkg::aicp_decode(evt_ff.data);
    nxt_to_tgl = to_tgl_ff;
    nxt_to_cnt = to_cnt_ff;
    if (!busy_sy_ff[2] || act_hit) begin
      nxt_to_cnt = 15'h0000;
    end else if (mod_tick) begin
      if (to_cnt_ff + 15'h0001 >= to_limit) begin
        nxt_to_cnt = 15'h0000;
        nxt_to_tgl = ~to_tgl_ff;
      end else begin
        nxt_to_cnt = to_cnt_ff + 15'h0001;
      end
    end
    nxt_out_word = out_word_ff;
    nxt_result = result_ff;
    nxt_rdy_n = rdy_n_ff;
    nxt_rel_cnt = rel_cnt_ff;
    nxt_mode = mode_ff;
    nxt_wa = wa_ff;
    nxt_start = 1'b0;
    nxt_restart = 1'b0;
    nxt_sleep = 1'b0;
    nxt_rst = 1'b0;
    nxt_wr = 1'b0;
    nxt_wd = wd_ff;
    if (rel_cnt_ff != 6'h00) begin
      nxt_rel_cnt = rel_cnt_ff - 6'h01;
      if (rel_cnt_ff == 6'h01) nxt_rdy_n = 1'b0;
    end
    if (ev_hit) begin
      if (evt_ff.gen_call) begin
        nxt_rst = (evt_ff.data == `AICP_GC_RESET);
      end else if (evt_ff.is_data) begin
        nxt_wr = 1'b1;
        nxt_wd = evt_ff.data;
        nxt_restart = conv_busy;
        nxt_start = conv_busy;
      end else begin
        unique case (cmd)
          aicp_pkg::C_RESET: nxt_rst = 1'b1;
          aicp_pkg::C_START: begin
            nxt_start = 1'b1;
            nxt_restart = conv_busy;
            nxt_mode = conversion_mode_select;
          end
          aicp_pkg::C_SLEEP: nxt_sleep = 1'b1;
          aicp_pkg::C_FETCH: begin
            nxt_out_word = result_ff;
            nxt_rdy_n = 1'b1;
            nxt_rel_cnt = 6'h00;
          end
          aicp_pkg::C_REG_RD: nxt_out_word = {reg_file[evt_ff.data[3:2] * 8 +: 8], 16'h0000};
          aicp_pkg::C_REG_WR: nxt_wa = evt_ff.data[3:2];
          aicp_pkg::C_NONE: begin
          end
        endcase
      end
    end
    if (conv_done) begin
      if (conv_pos_ovr) nxt_result = `AICP_POS_FULL;
      else if (conv_neg_ovr) nxt_result = `AICP_NEG_FULL;
      else nxt_result = conv_result;
      if (!rdy_n_ff && mode_ff && !nxt_rdy_n) begin
        nxt_rdy_n = 1'b1;
        nxt_rel_cnt = 6'(`AICP_RELEASE_CYCLES);
      end else begin
        nxt_rdy_n = 1'b0;
        nxt_rel_cnt = 6'h00;
      end
    end
    if (nxt_rst) begin
      nxt_mode = 1'b0;
      nxt_rdy_n = 1'b1;
      nxt_rel_cnt = 6'h00;
      nxt_out_word = 24'h000000;
      nxt_wa = 2'h0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_sy_ff <= 3'h0;
      act_sy_ff <= 3'h0;
      busy_sy_ff <= 3'h0;
      to_tgl_ff <= 1'b0;
      to_cnt_ff <= 15'h0000;
      out_word_ff <= 24'h000000;
      result_ff <= 24'h000000;
      rdy_n_ff <= 1'b1;
      rel_cnt_ff <= 6'h00;
      mode_ff <= 1'b0;
      wa_ff <= 2'h0;
      start_ff <= 1'b0;
      restart_ff <= 1'b0;
      sleep_ff <= 1'b0;
      rst_ff <= 1'b0;
      wr_ff <= 1'b0;
      wd_ff <= 8'h00;
    end else begin
      ev_sy_ff <= {ev_sy_ff[1:0], evt_tgl_ff};
      act_sy_ff <= {act_sy_ff[1:0], act_tgl_ff};
      busy_sy_ff <= {busy_sy_ff[1:0], busy_ff};
      to_tgl_ff <= nxt_to_tgl;
      to_cnt_ff <= nxt_to_cnt;
      out_word_ff <= nxt_out_word;
      result_ff <= nxt_result;
      rdy_n_ff <= nxt_rdy_n;
      rel_cnt_ff <= nxt_rel_cnt;
      mode_ff <= nxt_mode;
      wa_ff <= nxt_wa;
      start_ff <= nxt_start;
      restart_ff <= nxt_restart;
      sleep_ff <= nxt_sleep;
      rst_ff <= nxt_rst;
      wr_ff <= nxt_wr;
      wd_ff <= nxt_wd;
    end
  end

  // Open-drain ready pin, driven only when low
  assign result_ready_n_o = 1'b0;
  assign result_ready_n_oe = ~rdy_n_ff;
  assign conv_start = start_ff;
  assign conv_restart = restart_ff;
  assign sleep_command = sleep_ff;
  assign device_reset = rst_ff;
  assign cont_mode = mode_ff;
  assign reg_wr_en = wr_ff;
  assign reg_wr_addr = wa_ff;
  assign reg_wr_data = wd_ff;
endmodule

// ==== tb/aicp_port_props.sv ====
// Purpose: Checker for the ADC command port
// Assumes: Bound to aicp_port
// Notes: Link checks on link_clk, the rest on clk
`timescale 1ns/1ps
module aicp_port_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic result_ready_n_o,
  input wire logic result_ready_n_oe,
  input wire logic conversion_mode_select,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic conv_restart,
  input wire logic sleep_command,
  input wire logic device_reset,
  input wire logic cont_mode,
  input wire logic reg_wr_en
);
  ready_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    conv_done && !result_ready_n_oe |=> result_ready_n_oe) else $error("ready pin not set");
  ready_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    conv_done && result_ready_n_oe && cont_mode |=> !result_ready_n_oe [*8] ##[15:20]
    result_ready_n_oe) else $error("ready release width wrong");
  open_drain_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sda_o && !result_ready_n_o) else $error("pin driven high");
  ack_scl_low_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    $changed(sda_oe) |-> !scl_i) else $error("sda moved while scl high");
  restart_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    conv_restart |-> conv_start) else $error("restart without start");
  mode_at_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(cont_mode) |-> conv_start || $past(conv_start) || device_reset
    || $past(device_reset)) else $error("mode changed without start");
  mode_follows_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(cont_mode) |-> $past(conversion_mode_select)) else $error("mode not from select");
  reset_single_a: assert property (@(posedge clk) disable iff (sys_rst)
    device_reset |-> ##[0:2] !cont_mode) else $error("reset kept continuous mode");
  sleep_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    sleep_command |=> !sleep_command) else $error("sleep request too long");
  wr_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr_en |=> !reg_wr_en) else $error("write strobe too long");
endmodule
bind aicp_port aicp_port_props u_props (
  .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .result_ready_n_o(result_ready_n_o),
  .result_ready_n_oe(result_ready_n_oe), .conversion_mode_select(conversion_mode_select),
  .conv_done(conv_done), .conv_start(conv_start), .conv_restart(conv_restart),
  .sleep_command(sleep_command), .device_reset(device_reset), .cont_mode(cont_mode),
  .reg_wr_en(reg_wr_en)
);

// ==== tb/aicp_ctl_model.sv ====
// Purpose: Bus controller model for the two-wire port
// Assumes: SDA pulled up outside
// Notes: half sets the bit rate
`timescale 1ns/1ps
module aicp_ctl_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda,
  output logic [7:0] rx_byte,
  output logic rx_tgl
);
  int half = 500;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rx_byte = 8'h00;
    rx_tgl = 1'b0;
  end
  task automatic bit_out(input logic b);
    #(half / 4) sda_low = !b;
    #(half * 3 / 4) scl = 1'b1;
    #(half) scl = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    #(half / 4) sda_low = 1'b0;
    #(half * 3 / 4) scl = 1'b1;
    #(half / 2) b = sda;
    #(half / 2) scl = 1'b0;
  endtask
  task automatic start();
    #(half / 4) sda_low = 1'b0;
    #(half) scl = 1'b1;
    #(half) sda_low = 1'b1;
    #(half) scl = 1'b0;
  endtask
  task automatic stop();
    #(half / 4) sda_low = 1'b1;
    #(half) scl = 1'b1;
    #(half) sda_low = 1'b0;
    #(half * 4);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    bit_in(a);
    ack = !a;
  endtask
  task automatic rbyte(input logic ack);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      bit_in(v[i]);
    end
    bit_out(!ack);
    rx_byte = v;
    rx_tgl = !rx_tgl;
  endtask
endmodule

// ==== tb/adc_i2c_command_port_test.sv ====
// Purpose: Self-checking bench of the ADC command port
// Assumes: Controller model drives the bus
// Notes: Timeouts shortened to 20 and 40 ticks
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
  end
module adc_i2c_command_port_test;
  logic clk, link_clk, sys_rst, scl, sda_low, sda, rx_tgl, mod_tick, conv_done;
  logic mode_sel, turbo, pos_ovr, neg_ovr, busy, ack, ready_n;
  logic [7:0] rx_byte, d;
  logic [6:0] dev_addr;
  logic [23:0] conv_result, last;
  logic [31:0] reg_file;
  logic [1:0] tick_cnt;
  logic sda_o, sda_oe, rdy_o, rdy_oe, conv_start, conv_restart, sleep_command;
  logic device_reset, cont_mode, reg_wr_en;
  logic [1:0] reg_wr_addr;
  logic [7:0] reg_wr_data;
  logic [14:0] ev_q[$];
  logic [7:0] rd_q[$];
  int n_errors = 0;
  int tests_run = 0;
  assign sda = !(sda_low || sda_oe);
  assign ready_n = !rdy_oe;
  aicp_port #(.TIMEOUT_NORMAL(20), .TIMEOUT_TURBO(40)) uut (
    .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .result_ready_n_o(rdy_o), .result_ready_n_oe(rdy_oe),
    .dev_addr(dev_addr), .conversion_mode_select(mode_sel), .turbo_mode(turbo),
    .mod_tick(mod_tick), .conv_done(conv_done), .conv_result(conv_result),
    .conv_pos_ovr(pos_ovr), .conv_neg_ovr(neg_ovr), .conv_busy(busy), .reg_file(reg_file),
    .conv_start(conv_start), .conv_restart(conv_restart), .sleep_command(sleep_command),
    .device_reset(device_reset), .cont_mode(cont_mode), .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data)
  );
  aicp_ctl_model ctl (
    .scl(scl), .sda_low(sda_low), .sda(sda), .rx_byte(rx_byte), .rx_tgl(rx_tgl)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = !link_clk;
  end
  always @(negedge clk) begin
    tick_cnt <= sys_rst ? 2'h0 : tick_cnt + 2'h1;
    mod_tick <= !sys_rst && tick_cnt == 2'h3;
  end
  always @(negedge clk) begin : ev_mon
    logic [14:0] e;
    logic [14:0] g;
    g = {conv_start, conv_restart, sleep_command, device_reset, reg_wr_en, 10'h000};
    if (reg_wr_en) g[9:0] = {reg_wr_addr, reg_wr_data};
    if (g[14:10] != 5'h00) begin
      e = ev_q.size() ? ev_q.pop_front() : 15'h7fff;
      `CHK("event", e, g)
    end
  end
  always @(rx_tgl) begin : rd_mon
    logic [7:0] e;
    if ($time > 0) begin
      e = rd_q.size() ? rd_q.pop_front() : ~rx_byte;
      `CHK("read byte", e, rx_byte)
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wtx(input logic [6:0] a, input int n, input logic [15:0] b, input logic ok);
    ctl.start();
    ctl.wbyte({a, 1'b0}, ack);
    `CHK("addr ack", ok, ack)
    for (int i = n - 1; i >= 0; i--) begin
      ctl.wbyte(b[8*i +: 8], ack);
      `CHK("data ack", ok, ack)
    end
    ctl.stop();
    @(negedge clk);
  endtask
  task automatic rtx(input int n);
    ctl.start();
    ctl.wbyte({dev_addr, 1'b1}, ack);
    `CHK("read addr ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      ctl.rbyte(i < n - 1);
    end
    ctl.stop();
    @(negedge clk);
  endtask
  task automatic done(input int k);
    @(negedge clk);
    conv_result = 24'($urandom);
    pos_ovr = k == 1;
    neg_ovr = k == 2;
    conv_done = 1'b1;
    last = pos_ovr ? 24'h7fffff : neg_ovr ? 24'h800000 : conv_result;
    @(negedge clk);
    conv_done = 1'b0;
  endtask
  task automatic fetch_read();
    wtx(dev_addr, 1, {8'h10, 4'h1, 4'($urandom)}, 1'b1);
    repeat (10) @(negedge clk);
    `CHK("ready after fetch", 1'b1, ready_n)
    rd_q.push_back(last[23:16]);
    rd_q.push_back(last[15:8]);
    rd_q.push_back(last[7:0]);
    rtx(3);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [14:0] e);
    ev_q.push_back(e);
    wtx(dev_addr, 1, {8'h00, c}, 1'b1);
  endtask
  initial begin
    #3500000;
    n_errors++;
    finish_test();
  end
  initial begin
    {sys_rst, conv_done, pos_ovr, neg_ovr, busy, mode_sel, turbo} = 7'h40;
    {tick_cnt, mod_tick, conv_result} = 27'h0000000;
    void'($urandom(32'hbb13));
    dev_addr = {3'h4, 4'($urandom)};
    reg_file = $urandom;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 3; k++) begin
      done(k);
      repeat (2) @(negedge clk);
      `CHK("ready set", 1'b0, ready_n)
      fetch_read();
    end
    $display("test results done");
    wtx(dev_addr ^ 7'h01, 1, 16'h0010, 1'b0);
    cmd({7'h04, 1'($urandom)}, 15'h4000);
    busy = 1'b1;
    cmd(8'h09, 15'h6000);
    busy = 1'b0;
    mode_sel = 1'b1;
    cmd(8'h08, 15'h4000);
    mode_sel = 1'b0;
    `CHK("cont mode", 1'b1, cont_mode)
    done(0);
    done(0);
    repeat (10) @(negedge clk);
    `CHK("ready released", 1'b1, ready_n)
    repeat (25) @(negedge clk);
    `CHK("ready again", 1'b0, ready_n)
    `CHK("mode held", 1'b1, cont_mode)
    fetch_read();
    busy = 1'b1;
    cmd(8'h08, 15'h6000);
    busy = 1'b0;
    $display("test starts done");
    cmd({7'h01, 1'($urandom)}, 15'h1000);
    cmd({7'h03, 1'($urandom)}, 15'h0800);
    `CHK("mode reset", 1'b0, cont_mode)
    ev_q.push_back(15'h0800);
    wtx(7'h00, 1, 16'h0006, 1'b1);
    d = 8'($urandom);
    busy = 1'b1;
    ev_q.push_back({5'h19, 2'h3, d});
    wtx(dev_addr, 2, {6'h13, 2'($urandom), d}, 1'b1);
    busy = 1'b0;
    ctl.half = 1250;
    wtx(dev_addr, 1, {8'h00, 8'h24}, 1'b1);
    rd_q.push_back(reg_file[15:8]);
    rd_q.push_back(8'h00);
    rtx(2);
    ctl.half = 500;
    $display("test commands done");
    turbo = 1'b1;
    ctl.start();
    ctl.wbyte({dev_addr, 1'b0}, ack);
    repeat (100) @(negedge clk);
    ev_q.push_back(15'h4000);
    ctl.wbyte(8'h08, ack);
    `CHK("turbo idle ack", 1'b1, ack)
    ctl.stop();
    @(negedge clk);
    turbo = 1'b0;
    ctl.start();
    ctl.wbyte({dev_addr, 1'b0}, ack);
    repeat (250) @(negedge clk);
    ctl.wbyte(8'h08, ack);
    `CHK("timeout nack", 1'b0, ack)
    ctl.stop();
    cmd(8'h02, 15'h1000);
    $display("test timeout done");
    repeat (20) @(negedge clk);
    `CHK("pending notes", 0, ev_q.size() + rd_q.size())
    finish_test();
  end
endmodule
